// ===== cau_cfg.svh
// Constants for the coax attachment unit control logic.
// Assumes a 40 MHz system clock and a 10 Mb/s trunk, so four clocks per cell.
// Notes on behaviour
// - At frame start no more than two outbound cells are dropped.
// - First medium bit may be malformed; later cells carry outbound data.
// - Outbound-to-medium latency stays under half a bit cell.
// - Transmit path never inverts polarity.
// - Outbound idle starts alarm test after 0.6-1.6 us for 10 cells.
// - At receive start no more than five cells are dropped.
// - Second and later inbound cells reproduce valid medium data.
// - Medium-to-inbound latency under half a cell, no inversion.
// - Transmit and receive paths run at the same time.
// - Without a collision, alarm test or jabber the indication pair stays quiet.
// - Collision drives a bit-rate square wave, duty within 40/60.
// - While sending, collision wave appears within nine bit times.
// - Never alarm with one or no transmitter on the medium.
// - Idle: may flag two others, must flag more; sending: flag any second.
// - Isolate command disables the transmitter within 20 ms.
// - Isolate leaves receive and collision paths working.
// - Jabber window 20-150 ms from output activity; then output blocked.
// - Jabber cut-off raises the collision indication.
// - Without monitor, jabber clears on reset or after 0.5 s.
// - With monitor, jabber clears only through monitor commands; the code also clears it on reset.
// - Every detected error drives the collision wave toward the station.
`ifndef CAU_CFG_SVH
`define CAU_CFG_SVH

`define CAU_CLK_MHZ 40
`define CAU_CLKS_PER_BIT 4
`define CAU_SQE_MIN_NS 600
`define CAU_SQE_MAX_NS 1600
`define CAU_SQE_MIN_CYC ((`CAU_SQE_MIN_NS * `CAU_CLK_MHZ + 999) / 1000)
`define CAU_SQE_MAX_CYC ((`CAU_SQE_MAX_NS * `CAU_CLK_MHZ) / 1000)
`define CAU_SQE_DLY_CYC ((`CAU_SQE_MIN_CYC + `CAU_SQE_MAX_CYC) / 2)
`define CAU_SQE_TEST_BITS 10
`define CAU_SQE_TEST_CYC (`CAU_SQE_TEST_BITS * `CAU_CLKS_PER_BIT)
`define CAU_ISO_QUIET_CYC 8
`define CAU_JAB_MIN_MS 20
`define CAU_JAB_CYC (`CAU_JAB_MIN_MS * `CAU_CLK_MHZ * 1000)
`define CAU_UNJAB_MS 500
`define CAU_UNJAB_CYC (`CAU_UNJAB_MS * `CAU_CLK_MHZ * 1000)
`define CAU_BUF_DEPTH 2

`endif

// ===== cau_pkg.sv
// Types shared by the coax attachment unit control logic.
// Assumes nothing beyond a SystemVerilog compiler.
package cau_pkg;

  // One sampled line: activity (not idle) and the data level.
  typedef struct packed {
    logic active;
    logic data;
  } cau_line_type;

  // Transmitter count estimated from the trunk level comparators.
  typedef enum logic [1:0] {
    LVL_NONE,
    LVL_ONE,
    LVL_TWO,
    LVL_MANY
  } cau_level_type;

  typedef enum logic [1:0] {
    SQE_IDLE,
    SQE_SEND,
    SQE_WAIT,
    SQE_TEST
  } cau_sqe_state_type;

endpackage

// ===== cau_pair_buf.sv
// Small first-in first-out buffer for the inbound line samples.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module cau_pair_buf #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 2
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);

  localparam int AW = (DEPTH > 2) ? $clog2(DEPTH) : 1;

  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic [DEPTH*WIDTH-1:0] flat;
  logic push;
  logic pop;

  if (DEPTH < 2 || WIDTH < 1) begin : g_bad
    $error("cau_pair_buf needs DEPTH >= 2 and WIDTH >= 1");
  end

  // A pop in the same cycle frees a slot, so a full buffer still accepts.
  assign o_out_valid = (cnt_ff != '0);
  assign o_in_ready = (cnt_ff != (AW+1)'(DEPTH)) || i_out_ready;
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = flat[int'(rd_ff)*WIDTH +: WIDTH];

  for (genvar g = 0; g < DEPTH; g++) begin : g_ent
    logic [WIDTH-1:0] ent_ff;
    always_ff @(posedge i_clk) begin
      if (i_srst) begin
        ent_ff <= '0;
      end else if (push && wr_ff == AW'(g)) begin
        ent_ff <= i_in_data;
      end
    end
    assign flat[g*WIDTH +: WIDTH] = ent_ff;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

endmodule // cau_pair_buf

`default_nettype wire

// ===== cau_top.sv
// Functional logic of a coax trunk attachment unit: transmit, receive,
// collision alarm, post-frame alarm test, isolate and jabber cut-off.
// Assumes all inputs are synchronous to i_clk and the analog front end
// reports the trunk level as an estimated number of transmitters.
`timescale 1ns/1ps
`default_nettype none
`include "cau_cfg.svh"

module cau_top #(
  parameter int JABBER_CYCLES = `CAU_JAB_CYC,
  parameter int UNJAB_CYCLES = `CAU_UNJAB_CYC,
  parameter bit HAS_MONITOR = 1'b1,
  parameter bit FLAG_TWO_OTHERS = 1'b0,
  parameter int BUF_DEPTH = `CAU_BUF_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire cau_pkg::cau_line_type i_outbound_pair,
  input wire cau_pkg::cau_line_type i_medium_rx,
  input wire cau_pkg::cau_level_type i_medium_level,
  input wire logic i_host_command_pair,
  input wire logic i_inbound_ready,
  output logic o_medium_ready,
  output cau_pkg::cau_line_type o_inbound_pair,
  output logic o_inbound_valid,
  output logic o_medium_tx,
  output logic o_medium_drive_en,
  output logic o_collision_indication_pair,
  output logic o_isolated,
  output logic o_jabber
);

  localparam int JW = $clog2(JABBER_CYCLES + 1);
  localparam int UW = $clog2(UNJAB_CYCLES + 1);
  localparam int LW = $bits(cau_pkg::cau_line_type);

  if (JABBER_CYCLES < 1 || UNJAB_CYCLES < 1 || BUF_DEPTH < 2) begin : g_bad
    $error("cau_top: counts must be positive and BUF_DEPTH at least 2");
  end

  logic tx_active;
  logic cmd_prev_ff;
  logic [3:0] quiet_cnt_ff;
  logic isolate_ff;
  logic iso_exit;
  logic [JW-1:0] jab_cnt_ff;
  logic jab_ff;
  logic [UW-1:0] unjab_cnt_ff;
  logic jab_clear;
  logic tx_data_ff;
  logic drive_ff;
  cau_pkg::cau_sqe_state_type sqe_st_ff;
  logic [7:0] sqe_cnt_ff;
  logic coll_now;
  logic coll_ff;
  logic alarm;
  logic [1:0] ph_ff;
  logic cip_ff;
  logic [LW-1:0] buf_out;

  assign tx_active = i_outbound_pair.active;

  // ---------------------------------------------------------------------
  // Isolate command sensing
  // ---------------------------------------------------------------------
  // The station toggles the command pair at the bit rate to isolate; a
  // few quiet clocks mean it has returned to the quiet line state.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cmd_prev_ff <= 1'b0;
    end else begin
      cmd_prev_ff <= i_host_command_pair;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      quiet_cnt_ff <= '0;
      isolate_ff <= 1'b0;
    end else if (!HAS_MONITOR) begin
      isolate_ff <= 1'b0;
    end else if (i_host_command_pair != cmd_prev_ff) begin
      quiet_cnt_ff <= '0;
      isolate_ff <= 1'b1;
    end else if (quiet_cnt_ff == 4'(`CAU_ISO_QUIET_CYC - 1)) begin
      isolate_ff <= 1'b0;
    end else begin
      quiet_cnt_ff <= quiet_cnt_ff + 1'b1;
    end
  end

  assign iso_exit = isolate_ff && (i_host_command_pair == cmd_prev_ff) &&
                    (quiet_cnt_ff == 4'(`CAU_ISO_QUIET_CYC - 1));

  // ---------------------------------------------------------------------
  // Jabber timer
  // ---------------------------------------------------------------------
  // Only outbound activity runs the timer; idle restarts it from zero.
  always_ff @(posedge i_clk) begin
    if (i_srst || !tx_active) begin
      jab_cnt_ff <= '0;
    end else if (!jab_ff && jab_cnt_ff != JW'(JABBER_CYCLES)) begin
      jab_cnt_ff <= jab_cnt_ff + 1'b1;
    end
  end

  // With a monitor the latch clears only on reset or when isolation is released,
  // so short of a reset the station must run the isolate sequence to recover a jabbering unit.
  assign jab_clear = HAS_MONITOR ? iso_exit :
                     (unjab_cnt_ff == UW'(UNJAB_CYCLES - 1));

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      jab_ff <= 1'b0;
    end else if (tx_active && !jab_ff &&
                 jab_cnt_ff == JW'(JABBER_CYCLES - 1)) begin
      jab_ff <= 1'b1;
    end else if (jab_clear) begin
      jab_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst || !jab_ff || HAS_MONITOR) begin
      unjab_cnt_ff <= '0;
    end else begin
      unjab_cnt_ff <= unjab_cnt_ff + 1'b1;
    end
  end

  // ---------------------------------------------------------------------
  // Transmit path
  // ---------------------------------------------------------------------
  // One register stage: 25 ns, no cells dropped, no inversion.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tx_data_ff <= 1'b0;
      drive_ff <= 1'b0;
    end else begin
      tx_data_ff <= i_outbound_pair.data;
      drive_ff <= tx_active && !isolate_ff && !jab_ff;
    end
  end

  assign o_medium_tx = tx_data_ff;
  assign o_medium_drive_en = drive_ff;

  // ---------------------------------------------------------------------
  // Post-frame alarm test
  // ---------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sqe_st_ff <= cau_pkg::SQE_IDLE;
      sqe_cnt_ff <= '0;
    end else begin
      case (sqe_st_ff)
        cau_pkg::SQE_IDLE: begin
          if (tx_active) begin
            sqe_st_ff <= cau_pkg::SQE_SEND;
          end
        end
        cau_pkg::SQE_SEND: begin
          if (!tx_active) begin
            sqe_st_ff <= cau_pkg::SQE_WAIT;
            sqe_cnt_ff <= '0;
          end
        end
        cau_pkg::SQE_WAIT: begin
          if (sqe_cnt_ff == 8'(`CAU_SQE_DLY_CYC - 1)) begin
            sqe_st_ff <= cau_pkg::SQE_TEST;
            sqe_cnt_ff <= '0;
          end else begin
            sqe_cnt_ff <= sqe_cnt_ff + 1'b1;
          end
        end
        cau_pkg::SQE_TEST: begin
          if (sqe_cnt_ff == 8'(`CAU_SQE_TEST_CYC - 1)) begin
            sqe_st_ff <= cau_pkg::SQE_IDLE;
            sqe_cnt_ff <= '0;
          end else begin
            sqe_cnt_ff <= sqe_cnt_ff + 1'b1;
          end
        end
        default: begin
          sqe_st_ff <= cau_pkg::SQE_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Collision detection and indication
  // ---------------------------------------------------------------------
  // Our own frame counts as one transmitter, so two on the trunk is a
  // collision while we send, and while idle only with FLAG_TWO_OTHERS.
  // Isolation does not touch this path.
  always_comb begin
    if (tx_active) begin
      coll_now = (i_medium_level == cau_pkg::LVL_TWO) ||
                 (i_medium_level == cau_pkg::LVL_MANY);
    end else begin
      coll_now = (i_medium_level == cau_pkg::LVL_MANY) ||
                 (FLAG_TWO_OTHERS && i_medium_level == cau_pkg::LVL_TWO);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      coll_ff <= 1'b0;
    end else begin
      coll_ff <= coll_now;
    end
  end

  assign alarm = coll_ff || jab_ff || (sqe_st_ff == cau_pkg::SQE_TEST);

  // Free-running phase; a wave period of four clocks is exactly the bit
  // rate with a 50/50 duty, well inside the allowed spread.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ph_ff <= '0;
    end else begin
      ph_ff <= ph_ff + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cip_ff <= 1'b0;
    end else begin
      cip_ff <= alarm & ph_ff[1];
    end
  end

  assign o_collision_indication_pair = cip_ff;
  assign o_isolated = isolate_ff;
  assign o_jabber = jab_ff;

  // ---------------------------------------------------------------------
  // Receive path
  // ---------------------------------------------------------------------
  // Every medium sample enters the buffer unless it is full and the station
  // is not ready; our own frame is included, so the station sees its own
  // transmission echoed back.
  cau_pair_buf #(
    .WIDTH(LW),
    .DEPTH(BUF_DEPTH)
  ) u_rx_buf (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_in_valid(1'b1),
    .o_in_ready(o_medium_ready),
    .i_in_data(i_medium_rx),
    .o_out_valid(o_inbound_valid),
    .i_out_ready(i_inbound_ready),
    .o_out_data(buf_out)
  );

  assign o_inbound_pair = cau_pkg::cau_line_type'(buf_out);

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  a_tx_no_invert: assert property (
    o_medium_drive_en |-> o_medium_tx == $past(i_outbound_pair.data))
    else $error("medium data differs from outbound data");

  a_tx_prompt: assert property (
    tx_active && !isolate_ff && !jab_ff |=> o_medium_drive_en)
    else $error("transmitter not driving one clock after outbound data");

  a_iso_blocks_tx: assert property (
    isolate_ff |=> !o_medium_drive_en)
    else $error("medium driven while isolated");

  a_jab_blocks_tx: assert property (
    jab_ff |=> !o_medium_drive_en)
    else $error("medium driven after jabber cut-off");

  a_jab_alarm: assert property (
    jab_ff [*4] |-> ##[0:4] o_collision_indication_pair)
    else $error("no collision wave after jabber cut-off");

  a_quiet_alone: assert property (
    !jab_ff && sqe_st_ff != cau_pkg::SQE_TEST &&
    i_medium_level inside {cau_pkg::LVL_NONE, cau_pkg::LVL_ONE}
    |=> !coll_ff)
    else $error("alarm raised with fewer than two transmitters");

  a_coll_fast: assert property (
    (tx_active && i_medium_level == cau_pkg::LVL_TWO) [*8]
    |-> ##[0:28] o_collision_indication_pair)
    else $error("collision wave late while sending");

  a_wave_shape: assert property (
    $rose(o_collision_indication_pair) && alarm && ph_ff == 2'd3
    |=> o_collision_indication_pair)
    else $error("collision wave high phase too short");

  a_sqe_start: assert property (
    sqe_st_ff == cau_pkg::SQE_SEND && !tx_active
    |-> ##[24:64] o_collision_indication_pair)
    else $error("post-frame alarm test outside its window");

  a_sqe_length: assert property (
    $rose(sqe_st_ff == cau_pkg::SQE_TEST)
    |-> ##39 sqe_st_ff == cau_pkg::SQE_TEST ##1 sqe_st_ff != cau_pkg::SQE_TEST)
    else $error("post-frame alarm test length wrong");

  a_rx_flows: assert property (
    i_inbound_ready |-> o_medium_ready)
    else $error("receive path refused a sample while station ready");

  a_jab_restart: assert property (
    !tx_active |=> jab_cnt_ff == '0)
    else $error("jabber timer kept counting over idle");

  c_sqe_test: cover property (
    sqe_st_ff == cau_pkg::SQE_TEST ##1 o_collision_indication_pair);
  c_coll_tx: cover property (tx_active && coll_ff);
  c_isolate: cover property ($fell(isolate_ff));
  c_jabber: cover property ($rose(jab_ff));

endmodule // cau_top

`default_nettype wire

// ===== cau_station_model.sv
// Behavioural station at the attachment interface: outbound and command pairs.
// Assumes the bench steers it with levels that are synchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none

module cau_station_model (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_frame_req,
  input wire logic i_data,
  input wire logic i_isolate,
  input wire logic i_stall,
  output cau_pkg::cau_line_type o_outbound_pair,
  output logic o_host_command_pair,
  output logic o_inbound_ready
);
  logic [1:0] ph_ff;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_outbound_pair <= 2'h0;
      o_host_command_pair <= 1'b0;
      o_inbound_ready <= 1'b1;
      ph_ff <= 2'h0;
    end else begin
      o_outbound_pair.active <= i_frame_req;
      // An idle pair must not look like a held bit, so its lead keeps moving.
      o_outbound_pair.data <= i_frame_req ? i_data : ~o_outbound_pair.data;
      ph_ff <= ph_ff + 2'h1;
      o_host_command_pair <= i_isolate & ph_ff[1];
      o_inbound_ready <= !i_stall;
    end
  end
endmodule // cau_station_model

`default_nettype wire

// ===== tb_cau_top.sv
// Self-checking bench for the attachment unit control logic.
// Assumes cau_pkg and the station model are compiled before this file.
`timescale 1ns/1ps
`default_nettype none

module tb_cau_top;
  localparam int JAB = 300;
  typedef struct {
    logic send;
    logic data;
    logic [1:0] rx;
    cau_pkg::cau_level_type level;
    int highs;
  } cau_row_type;

  logic i_clk, i_srst, frame_req, tx_data, isolate, stall, prev;
  logic i_host_command_pair, i_inbound_ready, o_medium_ready;
  logic o_inbound_valid, o_medium_tx, o_medium_drive_en, o_isolated;
  logic o_collision_indication_pair, o_jabber;
  cau_pkg::cau_line_type i_outbound_pair, i_medium_rx, o_inbound_pair;
  cau_pkg::cau_level_type i_medium_level;
  int num_errors = 0;
  int comparisons = 0;
  int highs, first, last;
  // A steady alarm wave shows exactly four high clocks in eight.
  cau_row_type rows [7] = '{
    '{1'b0, 1'b0, 2'h3, cau_pkg::LVL_NONE, 0},
    '{1'b0, 1'b1, 2'h2, cau_pkg::LVL_ONE, 0},
    '{1'b0, 1'b0, 2'h1, cau_pkg::LVL_TWO, 0},
    '{1'b0, 1'b1, 2'h3, cau_pkg::LVL_MANY, 4},
    '{1'b1, 1'b1, 2'h2, cau_pkg::LVL_TWO, 4},
    '{1'b1, 1'b0, 2'h3, cau_pkg::LVL_MANY, 4},
    '{1'b1, 1'b1, 2'h0, cau_pkg::LVL_ONE, 0}};

  cau_station_model u_station (
    .i_clk(i_clk), .i_srst(i_srst), .i_frame_req(frame_req),
    .i_data(tx_data), .i_isolate(isolate), .i_stall(stall),
    .o_outbound_pair(i_outbound_pair),
    .o_host_command_pair(i_host_command_pair),
    .o_inbound_ready(i_inbound_ready));

  cau_top #(.JABBER_CYCLES(JAB), .UNJAB_CYCLES(100)) u_dut (
    .i_clk(i_clk), .i_srst(i_srst), .i_outbound_pair(i_outbound_pair),
    .i_medium_rx(i_medium_rx), .i_medium_level(i_medium_level),
    .i_host_command_pair(i_host_command_pair),
    .i_inbound_ready(i_inbound_ready), .o_medium_ready(o_medium_ready),
    .o_inbound_pair(o_inbound_pair), .o_inbound_valid(o_inbound_valid),
    .o_medium_tx(o_medium_tx), .o_medium_drive_en(o_medium_drive_en),
    .o_collision_indication_pair(o_collision_indication_pair),
    .o_isolated(o_isolated), .o_jabber(o_jabber));

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic count_alarm(output int n);
    n = 0;
    repeat (8) begin
      @(negedge i_clk);
      if (o_collision_indication_pair === 1'b1) n++;
    end
  endtask

  task automatic stop_test;
    if (num_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // The whole sequence needs about 1200 clocks.
  initial begin
    tick(6000);
    num_errors++;
    stop_test();
  end

  // ---------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------
  initial begin
    i_srst = 1'b1;
    frame_req = 1'b0;
    tx_data = 1'b0;
    isolate = 1'b0;
    stall = 1'b0;
    i_medium_rx = 2'h0;
    i_medium_level = cau_pkg::LVL_NONE;
    tick(8);
    i_srst <= 1'b0;
    @(negedge i_clk);
    check(32'({o_medium_ready, o_medium_drive_en, o_isolated}), 32'h4);
    check(32'({o_collision_indication_pair, o_jabber}), 32'h0);
    foreach (rows[i]) begin
      @(posedge i_clk);
      frame_req <= rows[i].send;
      tx_data <= rows[i].data;
      i_medium_rx <= rows[i].rx;
      i_medium_level <= rows[i].level;
      tick(8);
      @(negedge i_clk);
      check(32'(o_medium_drive_en), 32'(rows[i].send));
      if (rows[i].send) check(32'(o_medium_tx), 32'(rows[i].data));
      check(32'({o_inbound_valid, o_inbound_pair}), 32'(rows[i].rx) + 4);
      count_alarm(highs);
      check(32'(highs), 32'(rows[i].highs));
    end
    // Hand-written cases: bit latency, post-frame test, isolate, buffer.
    for (int k = 0; k < 16; k++) begin
      @(posedge i_clk);
      tx_data <= k[0] ^ k[2];
      @(negedge i_clk);
      if (k > 1) check(32'(o_medium_tx), 32'(prev));
      prev = i_outbound_pair.data;
    end
    @(posedge i_clk);
    frame_req <= 1'b0;
    i_medium_level <= cau_pkg::LVL_NONE;
    first = 0;
    last = 0;
    for (int k = 1; k <= 120; k++) begin
      @(negedge i_clk);
      if (o_collision_indication_pair === 1'b1) begin
        if (first == 0) first = k;
        last = k;
      end
    end
    check(32'(first >= 24 && first <= 70), 32'h1);
    check(32'(last - first >= 16 && last - first <= 60), 32'h1);
    @(posedge i_clk);
    frame_req <= 1'b1;
    isolate <= 1'b1;
    i_medium_rx <= 2'h3;
    i_medium_level <= cau_pkg::LVL_MANY;
    tick(8);
    @(negedge i_clk);
    check(32'({o_isolated, o_medium_drive_en}), 32'h2);
    check(32'(o_inbound_pair), 32'h3);
    count_alarm(highs);
    check(32'(highs), 32'h4);
    @(posedge i_clk);
    frame_req <= 1'b0;
    isolate <= 1'b0;
    i_medium_level <= cau_pkg::LVL_NONE;
    tick(120);
    @(negedge i_clk);
    check(32'(o_isolated), 32'h0);
    @(posedge i_clk);
    stall <= 1'b1;
    i_medium_rx <= 2'h1;
    @(posedge i_clk);
    i_medium_rx <= 2'h2;
    @(posedge i_clk);
    i_medium_rx <= 2'h0;
    @(negedge i_clk);
    check(32'({o_medium_ready, o_inbound_valid, o_inbound_pair}), 32'h5);
    @(posedge i_clk);
    stall <= 1'b0;
    tick(2);
    @(negedge i_clk);
    check(32'(o_inbound_pair), 32'h2);
    // Jabber: one frame just under the window, then one that runs over it.
    @(posedge i_clk);
    frame_req <= 1'b1;
    tick(JAB - 10);
    frame_req <= 1'b0;
    tick(3);
    frame_req <= 1'b1;
    tick(JAB - 10);
    @(negedge i_clk);
    check(32'(o_jabber), 32'h0);
    tick(20);
    @(negedge i_clk);
    check(32'({o_jabber, o_medium_drive_en}), 32'h2);
    count_alarm(highs);
    check(32'(highs), 32'h4);
    @(posedge i_clk);
    frame_req <= 1'b0;
    tick(150);
    @(negedge i_clk);
    check(32'(o_jabber), 32'h1);
    @(posedge i_clk);
    isolate <= 1'b1;
    tick(12);
    isolate <= 1'b0;
    tick(20);
    @(negedge i_clk);
    check(32'({o_isolated, o_jabber}), 32'h0);
    stop_test();
  end
endmodule // tb_cau_top

`default_nettype wire
